// ===== logic/pmc_defines.vh
// Constants shared by the management and strap-configuration block.
// Included by bare name from the frame engine, the top level and the bench; the reset stretcher does not include it.
`ifndef PMC_DEFINES_VH
`define PMC_DEFINES_VH

// ******************************************************************
// Register bus offsets (byte addresses, one 32-bit word each).
// ******************************************************************
`define PMC_OFS_CTRL 5'h00
`define PMC_OFS_STATUS 5'h04
`define PMC_OFS_IRQ_STAT 5'h08
`define PMC_OFS_IRQ_MASK 5'h0C

// Control and interrupt fields.
`define PMC_CTRL_SOFT_RST 0
`define PMC_IRQ_W 5
`define PMC_IRQ_RESET_DONE 0
`define PMC_IRQ_MDIO_WR 1
`define PMC_IRQ_MDIO_RD 2
`define PMC_IRQ_BLOCKED 3
`define PMC_IRQ_STAT_CHG 4
`define PMC_IRQ_MASK_RST 5'h00

// ******************************************************************
// Serial management frame and register map.
// ******************************************************************
`define PMC_PRE_ONES 6'h20
`define PMC_OP_WRITE 2'h1
`define PMC_OP_READ 2'h2
`define PMC_MREG_CTRL 5'h00
`define PMC_MREG_MODE 5'h10
`define PMC_MREG_INT_EN 5'h12
`define PMC_MREG_INT_STAT 5'h13
`define PMC_MREG_RST 16'h0000
`define PMC_CTRL_RESET_BIT 15
`define PMC_MODE_FIBER_BIT 0
`define PMC_INT_EN_BIT 1
`define PMC_INT_STAT_CHG_BIT 2

// ******************************************************************
// Timing.
// ******************************************************************
`define PMC_CLK_MHZ 100
`define PMC_RESET_EXT_NS 258000

`endif

// ===== logic/pmc_reset_seq.v
// Reset stretcher and strap latch of the management block.
// Assumes the reset request and strap pins are already synchronised.
`timescale 1ns/1ns
`default_nettype none
module pmc_reset_seq #(
   parameter EXT_CYCLES = 25800
) (
   input wire clk,
   input wire rst,
   input wire req,
   input wire media_pin,
   input wire [4:0] addr_pin,
   output reg busy_q,
   output reg done_q,
   output reg fiber_q,
   output reg [4:0] addr_q
);

   // The count is cut to the counter width on purpose.
   localparam [31:0] LAST_W = EXT_CYCLES - 1;
   localparam [23:0] LAST = LAST_W[23:0];
   reg [23:0] cnt_q;

   // The reset cycle runs on for a fixed time after the request drops.
   always @(posedge clk) begin
      if (rst) begin
         busy_q <= 1'b1;
         done_q <= 1'b0;
         fiber_q <= 1'b0;
         addr_q <= 5'h00;
         cnt_q <= 24'h000000;
      end else begin
         done_q <= 1'b0;
         if (req) begin
            busy_q <= 1'b1;
            cnt_q <= 24'h000000;
         end else if (busy_q) begin
            if (cnt_q == LAST) begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
               fiber_q <= media_pin;
               addr_q <= addr_pin;
            end else begin
               cnt_q <= cnt_q + 24'h000001;
            end
         end
      end
   end

endmodule
`default_nettype wire

// ===== logic/pmc_mdio_slave.v
// Serial management frame engine: decodes frames, answers reads.
// Assumes a one-cycle pulse at each management clock rising edge and
// a synchronised data sample that is stable at that pulse.
`timescale 1ns/1ns
`default_nettype none
`include "pmc_defines.vh"
module pmc_mdio_slave (
   input wire clk,
   input wire rst,
   input wire mdc_rise,
   input wire mdio_in,
   input wire [4:0] phy_addr,
   input wire access_off,
   input wire [15:0] rd_data,
   output reg [4:0] reg_addr_q,
   output reg rd_pulse_q,
   output reg wr_pulse_q,
   output reg blk_pulse_q,
   output reg [15:0] wr_data_q,
   output reg mdio_o_q,
   output reg mdio_oe_q
);

   localparam [3:0] S_PRE = 4'h1;
   localparam [3:0] S_HDR = 4'h2;
   localparam [3:0] S_TA = 4'h4;
   localparam [3:0] S_DATA = 4'h8;

   reg [3:0] st_q;
   reg [5:0] ones_q;
   reg [4:0] cnt_q;
   reg [15:0] sh_q;
   reg is_rd_q;
   wire [12:0] hdr = {sh_q[11:0], mdio_in};
   wire hdr_ok = hdr[12] && (hdr[9:5] == phy_addr) &&
      (hdr[11:10] == `PMC_OP_READ || hdr[11:10] == `PMC_OP_WRITE);

   // All moves happen on the management clock rising edge.
   always @(posedge clk) begin
      if (rst) begin
         st_q <= S_PRE;
         ones_q <= 6'h00;
         cnt_q <= 5'h00;
         sh_q <= 16'h0000;
         is_rd_q <= 1'b0;
         reg_addr_q <= 5'h00;
         rd_pulse_q <= 1'b0;
         wr_pulse_q <= 1'b0;
         blk_pulse_q <= 1'b0;
         wr_data_q <= 16'h0000;
         mdio_o_q <= 1'b0;
         mdio_oe_q <= 1'b0;
      end else begin
         rd_pulse_q <= 1'b0;
         wr_pulse_q <= 1'b0;
         blk_pulse_q <= 1'b0;
         if (mdc_rise) begin
            case (st_q)
               S_PRE: begin
                  if (mdio_in) begin
                     if (ones_q != `PMC_PRE_ONES) begin
                        ones_q <= ones_q + 6'h01;
                     end
                  end else begin
                     if (ones_q == `PMC_PRE_ONES) begin
                        st_q <= S_HDR;
                        cnt_q <= 5'h00;
                     end
                     ones_q <= 6'h00;
                  end
               end
               S_HDR: begin
                  sh_q <= {sh_q[14:0], mdio_in};
                  cnt_q <= cnt_q + 5'h01;
                  if (cnt_q == 5'h0C) begin
                     cnt_q <= 5'h00;
                     reg_addr_q <= hdr[4:0];
                     is_rd_q <= (hdr[11:10] == `PMC_OP_READ);
                     if (hdr_ok && !access_off) begin
                        st_q <= S_TA;
                     end else begin
                        blk_pulse_q <= hdr_ok;
                        st_q <= S_PRE;
                     end
                  end
               end
               S_TA: begin
                  cnt_q <= cnt_q + 5'h01;
                  if (cnt_q == 5'h00) begin
                     if (is_rd_q) begin
                        mdio_oe_q <= 1'b1;
                        mdio_o_q <= 1'b0;
                        sh_q <= rd_data;
                        rd_pulse_q <= 1'b1;
                     end
                  end else begin
                     st_q <= S_DATA;
                     cnt_q <= 5'h00;
                     if (is_rd_q) begin
                        mdio_o_q <= sh_q[15];
                        sh_q <= {sh_q[14:0], 1'b0};
                     end
                  end
               end
               S_DATA: begin
                  cnt_q <= cnt_q + 5'h01;
                  if (is_rd_q) begin
                     mdio_o_q <= sh_q[15];
                     sh_q <= {sh_q[14:0], 1'b0};
                  end else begin
                     sh_q <= {sh_q[14:0], mdio_in};
                  end
                  if (cnt_q == 5'h0F) begin
                     st_q <= S_PRE;
                     mdio_oe_q <= 1'b0;
                     mdio_o_q <= 1'b0;
                     wr_pulse_q <= !is_rd_q;
                     wr_data_q <= {sh_q[14:0], mdio_in};
                  end
               end
               default: begin
                  st_q <= S_PRE;
                  mdio_oe_q <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule
`default_nettype wire

// ===== logic/pmc_top.v
// Management and strap-configuration logic of a 10/100 transceiver.
// Holds the serial management register set, the reset stretcher,
// the strap latch, the status-change interrupt pin and an
// Avalon-MM register window for local software.
// Assumes one 100 MHz clock; every pin input is asynchronous to it,
// and the management clock is slower than a quarter of it.
`timescale 1ns/1ns
`default_nettype none
`include "pmc_defines.vh"
module pmc_top #(
   parameter RESET_EXT_CYCLES = (`PMC_RESET_EXT_NS * `PMC_CLK_MHZ) / 1000
) (
   input wire core_clk,
   input wire rst,
   input wire [4:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   output reg irq,
   input wire hw_reset_n,
   input wire mgmt_access_disable,
   input wire mdc,
   input wire mdio_i,
   output wire mdio_o,
   output wire mdio_oe,
   output wire status_change_irq_n_o,
   output reg status_change_irq_n_oe,
   input wire signal_detect_media_sel,
   input wire [4:0] phy_addr_strap,
   output reg fiber_mode,
   output reg signal_detect,
   input wire status_event
);

   // ***************************************************************
   // Pin synchronisers.
   // ***************************************************************
   // Order: addr(5), reset_n, disable, media, mdio, mdc.
   wire [9:0] pins = {phy_addr_strap, hw_reset_n, mgmt_access_disable,
      signal_detect_media_sel, mdio_i, mdc};
   reg [9:0] pin_m_q;
   reg [9:0] pin_s_q;
   reg mdc_prev_q;

   // The first stage feeds only the second stage.
   always @(posedge core_clk) begin
      if (rst) begin
         pin_m_q <= 10'h010;
         pin_s_q <= 10'h010;
         mdc_prev_q <= 1'b0;
      end else begin
         pin_m_q <= pins;
         pin_s_q <= pin_m_q;
         mdc_prev_q <= pin_s_q[0];
      end
   end

   wire mdc_rise = pin_s_q[0] && !mdc_prev_q;
   wire mdio_s = pin_s_q[1];
   wire media_s = pin_s_q[2];
   wire dis_s = pin_s_q[3];
   wire hw_rst_n_s = pin_s_q[4];
   wire [4:0] addr_s = pin_s_q[9:5];

   // ***************************************************************
   // Reset sequencing and straps.
   // ***************************************************************
   reg soft_rst_q;
   reg mreg_rst_q;
   wire busy;
   wire done;
   wire fiber_strap;
   wire [4:0] dev_addr;

   wire rst_req = !hw_rst_n_s || soft_rst_q || mreg_rst_q;

   pmc_reset_seq #(
      .EXT_CYCLES(RESET_EXT_CYCLES)
   ) u_rst (
      .clk(core_clk),
      .rst(rst),
      .req(rst_req),
      .media_pin(media_s),
      .addr_pin(addr_s),
      .busy_q(busy),
      .done_q(done),
      .fiber_q(fiber_strap),
      .addr_q(dev_addr)
   );

   wire dev_rst = rst || busy;

   // ***************************************************************
   // Serial management port.
   // ***************************************************************
   wire [4:0] m_addr;
   wire m_rd;
   wire m_wr;
   wire m_blk;
   wire [15:0] m_wdata;
   reg [15:0] m_rdata;

   pmc_mdio_slave u_mdio (
      .clk(core_clk),
      .rst(dev_rst),
      .mdc_rise(mdc_rise),
      .mdio_in(mdio_s),
      .phy_addr(dev_addr),
      .access_off(dis_s),
      .rd_data(m_rdata),
      .reg_addr_q(m_addr),
      .rd_pulse_q(m_rd),
      .wr_pulse_q(m_wr),
      .blk_pulse_q(m_blk),
      .wr_data_q(m_wdata),
      .mdio_o_q(mdio_o),
      .mdio_oe_q(mdio_oe)
   );

   // ***************************************************************
   // Management register set.
   // ***************************************************************
   reg [14:0] mctrl_q;
   reg [15:0] mmode_q;
   reg [15:0] minten_q;
   reg chg_pend_q;
   reg sd_prev_q;
   wire chg_ev;

   // Write-only-when-addressed registers; only the mode fiber bit default comes from the strap.
   always @(posedge core_clk) begin
      if (dev_rst) begin
         mctrl_q <= 15'h0000;
         mmode_q <= `PMC_MREG_RST;
         minten_q <= `PMC_MREG_RST;
         mreg_rst_q <= 1'b0;
      end else begin
         mreg_rst_q <= 1'b0;
         if (done) begin
            mmode_q[`PMC_MODE_FIBER_BIT] <= fiber_strap;
         end else if (m_wr) begin
            case (m_addr)
               `PMC_MREG_CTRL: begin
                  mctrl_q <= m_wdata[14:0];
                  mreg_rst_q <= m_wdata[`PMC_CTRL_RESET_BIT];
               end
               `PMC_MREG_MODE: mmode_q <= m_wdata;
               `PMC_MREG_INT_EN: minten_q <= m_wdata;
               default: mctrl_q <= mctrl_q;
            endcase
         end
      end
   end

   // Read data is picked by the register address the frame carries.
   always @* begin
      case (m_addr)
         `PMC_MREG_CTRL: m_rdata = {1'b0, mctrl_q};
         `PMC_MREG_MODE: m_rdata = mmode_q;
         `PMC_MREG_INT_EN: m_rdata = minten_q;
         `PMC_MREG_INT_STAT: m_rdata = {13'h0000, chg_pend_q, 2'h0};
         default: m_rdata = 16'h0000;
      endcase
   end

   // ***************************************************************
   // Media mode, signal detect and the status-change pin.
   // ***************************************************************
   wire fiber_now = mmode_q[`PMC_MODE_FIBER_BIT];
   wire sd_now = fiber_now && !busy && media_s;
   assign chg_ev = (sd_now != sd_prev_q) || status_event;

   // A change caught in the clearing cycle stays pending.
   always @(posedge core_clk) begin
      if (dev_rst) begin
         chg_pend_q <= 1'b0;
         sd_prev_q <= 1'b0;
      end else begin
         sd_prev_q <= sd_now;
         if (chg_ev) begin
            chg_pend_q <= 1'b1;
         end else if (m_rd && m_addr == `PMC_MREG_INT_STAT) begin
            chg_pend_q <= 1'b0;
         end
      end
   end

   // Open drain: the pin is only ever pulled low or released.
   assign status_change_irq_n_o = 1'b0;

   // Pin and mode outputs, all registered.
   always @(posedge core_clk) begin
      if (dev_rst) begin
         status_change_irq_n_oe <= 1'b0;
         fiber_mode <= 1'b0;
         signal_detect <= 1'b0;
      end else begin
         status_change_irq_n_oe <= chg_pend_q && minten_q[`PMC_INT_EN_BIT];
         fiber_mode <= fiber_now;
         signal_detect <= sd_now;
      end
   end

   // ***************************************************************
   // Avalon-MM register window.
   // ***************************************************************
   reg [4:0] irq_stat_q;
   reg [4:0] irq_mask_q;
   wire req = avs_read || avs_write;
   wire acc = req && !avs_waitrequest;
   wire wr_acc = acc && avs_write && avs_byteenable[0];
   wire [4:0] events = {chg_ev, m_blk, m_rd, m_wr, done};
   reg [4:0] w1c;
   reg [4:0] irq_stat_d;
   reg [31:0] rdata_d;

   // Next interrupt status: set beats a clear in the same cycle.
   always @* begin
      w1c = 5'h00;
      if (wr_acc && avs_address == `PMC_OFS_IRQ_STAT) begin
         w1c = avs_writedata[4:0];
      end
      irq_stat_d = (irq_stat_q & ~w1c) | events;
   end

   // Read mux; unmapped offsets read as zero.
   always @* begin
      case (avs_address)
         `PMC_OFS_CTRL: rdata_d = {31'h00000000, soft_rst_q};
         `PMC_OFS_STATUS: rdata_d = {22'h000000, chg_pend_q, dev_addr,
            dis_s, sd_now, fiber_now, busy};
         `PMC_OFS_IRQ_STAT: rdata_d = {27'h0000000, irq_stat_q};
         `PMC_OFS_IRQ_MASK: rdata_d = {27'h0000000, irq_mask_q};
         default: rdata_d = 32'h00000000;
      endcase
   end

   // One wait cycle per access keeps read data and outputs registered.
   always @(posedge core_clk) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h00000000;
         irq_stat_q <= 5'h00;
         irq_mask_q <= `PMC_IRQ_MASK_RST;
         soft_rst_q <= 1'b0;
         irq <= 1'b0;
      end else begin
         avs_waitrequest <= !(req && avs_waitrequest);
         if (req && avs_waitrequest) begin
            avs_readdata <= avs_read ? rdata_d : 32'h00000000;
         end
         irq_stat_q <= irq_stat_d;
         irq <= |(irq_stat_d & irq_mask_q);
         soft_rst_q <= 1'b0;
         if (wr_acc && avs_address == `PMC_OFS_CTRL) begin
            soft_rst_q <= avs_writedata[`PMC_CTRL_SOFT_RST];
         end
         if (wr_acc && avs_address == `PMC_OFS_IRQ_MASK) begin
            irq_mask_q <= avs_writedata[4:0];
         end
      end
   end

endmodule
`default_nettype wire

// ===== verification/pmc_props.sv
// Checker for the management and strap block, seen from its top ports.
// Assumes one core clock domain with a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module pmc_props (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic irq,
   input wire logic mgmt_access_disable,
   input wire logic mdio_o,
   input wire logic mdio_oe,
   input wire logic status_change_irq_n_o,
   input wire logic status_change_irq_n_oe,
   input wire logic signal_detect_media_sel,
   input wire logic fiber_mode,
   input wire logic signal_detect
);
   // ******************************************************************
   // Helper logic and properties
   // ******************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   logic [15:0] oe_cnt_q;
   // Counts how long the device has held the data line, so a stuck enable shows.
   always_ff @(posedge core_clk) begin
      if (rst || !mdio_oe) oe_cnt_q <= 16'h0000;
      else oe_cnt_q <= oe_cnt_q + 16'h0001;
   end
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_dis_held;
      mgmt_access_disable [*4] ##0 !mdio_oe;
   endsequence
   property p_req_answer; s_req |=> !avs_waitrequest; endproperty
   property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
   property p_reset_quiet;
      disable iff (1'b0) rst |=> avs_waitrequest && !irq && !mdio_oe && !status_change_irq_n_oe;
   endproperty
   property p_od_zero; status_change_irq_n_o == 1'b0; endproperty
   property p_dis_no_drive; s_dis_held |=> !mdio_oe; endproperty
   property p_ta_zero; $rose(mdio_oe) |-> mdio_o == 1'b0; endproperty
   property p_oe_bound; oe_cnt_q <= 16'd240; endproperty
   property p_sd_fiber; signal_detect |-> fiber_mode || $past(fiber_mode); endproperty
   property p_sd_low; !signal_detect_media_sel [*6] |-> !signal_detect; endproperty
   a_req_answer: assert property (p_req_answer) else $error("no answer one cycle after request");
   a_wait_one: assert property (p_wait_one) else $error("waitrequest low for over one cycle");
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not idle in reset");
   a_od_zero: assert property (p_od_zero) else $error("open drain pin drives high");
   a_dis_no_drive: assert property (p_dis_no_drive) else $error("drive while disabled");
   a_ta_zero: assert property (p_ta_zero) else $error("turnaround bit not zero");
   a_oe_bound: assert property (p_oe_bound) else $error("data line held too long");
   a_sd_fiber: assert property (p_sd_fiber) else $error("signal detect outside fiber");
   a_sd_low: assert property (p_sd_low) else $error("signal detect without pin");
endmodule
bind pmc_top pmc_props u_props (.core_clk(core_clk), .rst(rst), .avs_read(avs_read),
   .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .irq(irq),
   .mgmt_access_disable(mgmt_access_disable), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
   .status_change_irq_n_o(status_change_irq_n_o),
   .status_change_irq_n_oe(status_change_irq_n_oe),
   .signal_detect_media_sel(signal_detect_media_sel), .fiber_mode(fiber_mode),
   .signal_detect(signal_detect));
`default_nettype wire

// ===== verification/pmc_sta_model.sv
// Station management controller model: clock and data line per frame.
// Assumes the bench resolves the shared data line with a pull-up.
`timescale 1ns/1ns
`default_nettype none
module pmc_sta_model (
   output logic mdc,
   output logic sta_o,
   output logic sta_oe,
   input wire logic mdio_line
);
   // ******************************************************************
   // Frame engine
   // ******************************************************************
   // Idle: clock stands low and the line is released.
   initial begin
      mdc = 1'b0;
      sta_o = 1'b1;
      sta_oe = 1'b0;
   end
   // clock and framing
   // The 125 ns period keeps the clock at 8 MHz; it runs only in frames.
   task automatic frame(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd, output logic [15:0] q);
      logic [63:0] v;
      v = {32'hFFFFFFFF, 2'b01, rd ? 2'b10 : 2'b01, pa, ra, 2'b10, wd};
      q = 16'h0000;
      for (int i = 63; i >= 0; i--) begin
         sta_oe = !(rd && i < 18);
         sta_o = v[i];
         #62;
         q = {q[14:0], mdio_line};
         mdc = 1'b1;
         #63;
         mdc = 1'b0;
      end
      sta_oe = 1'b0;
      #100;
   endtask
endmodule
`default_nettype wire

// ===== verification/test_phy_mgmt_config_port.sv
// Self-checking bench for the management and strap block.
// Assumes the station model and the bound checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "pmc_defines.vh"
module test_phy_mgmt_config_port;
   localparam int LIMIT = 40000;
   logic core_clk, rst, avs_read, avs_write, avs_waitrequest, irq, hw_reset_n;
   logic mgmt_access_disable, mdc, mdio_o, mdio_oe, irq_n_o, irq_n_oe, sta_o, sta_oe;
   logic signal_detect_media_sel, fiber_mode, signal_detect, status_event;
   logic [4:0] avs_address, phy_addr_strap;
   logic [31:0] avs_writedata, avs_readdata, r;
   logic [3:0] avs_byteenable;
   logic [15:0] q;
   wire mdio_line;
   int miscompares, checks, cycles;
   // Shared data line with pull-up: whoever enables drives it.
   assign mdio_line = mdio_oe ? mdio_o : (sta_oe ? sta_o : 1'b1);
   pmc_top #(.RESET_EXT_CYCLES(40)) uut (.core_clk(core_clk), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
      .hw_reset_n(hw_reset_n), .mgmt_access_disable(mgmt_access_disable), .mdc(mdc),
      .mdio_i(mdio_line), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
      .status_change_irq_n_o(irq_n_o), .status_change_irq_n_oe(irq_n_oe),
      .signal_detect_media_sel(signal_detect_media_sel), .phy_addr_strap(phy_addr_strap),
      .fiber_mode(fiber_mode), .signal_detect(signal_detect), .status_event(status_event));
   pmc_sta_model sta (.mdc(mdc), .sta_o(sta_o), .sta_oe(sta_oe), .mdio_line(mdio_line));
   // ******************************************************************
   // Tasks
   // ******************************************************************
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic complete_run;
      $display("mismatches %0d of %0d checks", miscompares, checks);
      if (miscompares == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Request held until waitrequest is seen low at a rising edge.
   task automatic av_wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= 1'b1;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
   endtask
   task automatic av_rd(input logic [4:0] a, output logic [31:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
   endtask
   task automatic mg(input logic rd, input logic [4:0] ra, input logic [15:0] wd);
      sta.frame(rd, 5'h0A, ra, wd, q);
   endtask
   task automatic wait_ready;
      r = 32'h1;
      for (int n = 0; n < 100 && r[0] !== 1'b0; n++) av_rd(`PMC_OFS_STATUS, r);
      chk("ready", 32'h0, {31'h0, r[0]});
   endtask
   task automatic pulse_event;
      @(posedge core_clk) status_event <= 1'b1;
      @(posedge core_clk) status_event <= 1'b0;
      repeat (6) @(posedge core_clk);
   endtask
   // Hang guard: a run past the ceiling counts as a mismatch.
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         miscompares++;
         complete_run;
      end
   end
   // ******************************************************************
   // Main sequence
   // ******************************************************************
   initial begin
      {rst, hw_reset_n, signal_detect_media_sel} = 3'b111;
      {avs_read, avs_write, mgmt_access_disable, status_event} = 4'h0;
      avs_address = 5'h00;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      phy_addr_strap = 5'h0A;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      av_rd(`PMC_OFS_STATUS, r); chk("in reset", 32'h1, {31'h0, r[0]});
      wait_ready;
      av_rd(`PMC_OFS_STATUS, r); chk("status", 32'h000002A6, r);
      chk("sd fiber", 32'h1, {31'h0, signal_detect});
      chk("fiber on", 32'h1, {31'h0, fiber_mode});
      av_rd(`PMC_OFS_IRQ_MASK, r); chk("mask reset", 32'h0, r);
      av_wr(`PMC_OFS_IRQ_MASK, 32'h1, 4'hE); av_rd(`PMC_OFS_IRQ_MASK, r); chk("be0 off", 32'h0, r);
      av_rd(5'h10, r); chk("unmapped", 32'h0, r);
      av_wr(`PMC_OFS_IRQ_MASK, 32'h1, 4'hF); repeat (3) @(posedge core_clk);
      chk("irq on", 32'h1, {31'h0, irq});
      av_wr(`PMC_OFS_IRQ_STAT, 32'h1, 4'hF); repeat (3) @(posedge core_clk);
      chk("irq off", 32'h0, {31'h0, irq});
      mg(1'b1, `PMC_MREG_MODE, 16'h0); chk("mode strap", 32'h1, {16'h0, q});
      mg(1'b0, `PMC_MREG_MODE, 16'h0); mg(1'b1, `PMC_MREG_MODE, 16'h0);
      chk("mode write", 32'h0, {16'h0, q});
      chk("fiber off", 32'h0, {31'h0, fiber_mode});
      chk("sd twisted", 32'h0, {31'h0, signal_detect});
      sta.frame(1'b0, 5'h0B, `PMC_MREG_MODE, 16'h1, q);
      mg(1'b1, `PMC_MREG_MODE, 16'h0); chk("other addr", 32'h0, {16'h0, q});
      @(posedge core_clk);
      mgmt_access_disable <= 1'b1;
      mg(1'b0, `PMC_MREG_MODE, 16'h1); mg(1'b1, `PMC_MREG_MODE, 16'h0);
      chk("blocked read", 32'hFFFF, {16'h0, q});
      @(posedge core_clk);
      mgmt_access_disable <= 1'b0;
      av_rd(`PMC_OFS_IRQ_STAT, r); chk("blocked flag", 32'h1, {31'h0, r[3]});
      mg(1'b1, `PMC_MREG_MODE, 16'h0); chk("not written", 32'h0, {16'h0, q});
      pulse_event; chk("pin idle", 32'h0, {31'h0, irq_n_oe});
      mg(1'b1, `PMC_MREG_INT_STAT, 16'h0);
      mg(1'b0, `PMC_MREG_INT_EN, 16'h0002);
      pulse_event; chk("pin low", 32'h1, {31'h0, irq_n_oe});
      mg(1'b1, `PMC_MREG_INT_STAT, 16'h0); chk("pending", 32'h1, {31'h0, q[2]});
      chk("pin freed", 32'h0, {31'h0, irq_n_oe});
      mg(1'b0, `PMC_MREG_CTRL, 16'h8000);
      av_rd(`PMC_OFS_STATUS, r); chk("soft reset", 32'h1, {31'h0, r[0]});
      wait_ready;
      mg(1'b1, `PMC_MREG_MODE, 16'h0); chk("relatched", 32'h1, {16'h0, q});
      @(posedge core_clk);
      signal_detect_media_sel <= 1'b0;
      hw_reset_n <= 1'b0;
      repeat (5) @(posedge core_clk);
      hw_reset_n <= 1'b1;
      wait_ready;
      chk("twisted", 32'h0, {31'h0, fiber_mode});
      signal_detect_media_sel <= 1'b1;
      repeat (10) @(posedge core_clk);
      chk("mode held", 32'h0, {31'h0, fiber_mode});
      mg(1'b1, `PMC_MREG_MODE, 16'h0); chk("bit clear", 32'h0, {16'h0, q});
      complete_run;
   end
endmodule
`default_nettype wire
